// ===== common/tupm_defs.svh
// Constants of the translation unit performance monitor counter group
`ifndef TUPM_DEFS_SVH
`define TUPM_DEFS_SVH

// Sizes
`define TUPM_COUNTER_NUMBER_FIELD 4
`define TUPM_CTR_W 32
`define TUPM_SID_W 16
`define TUPM_ADDR_W 13
`define TUPM_IDX_W 6

// Event codes
`define TUPM_EVT_WBUF_FULL 8'h87
`define TUPM_EVT_DCMO_DOWN 8'h8B
`define TUPM_EVT_STASH_FAIL 8'h8C

// Byte offsets; page 1 starts at 13'h1000
`define TUPM_OFF_CNT 13'h1000
`define TUPM_OFF_EVT 13'h1400
`define TUPM_OFF_FILT 13'h1A00
`define TUPM_OFF_CNTEN 13'h1C00
`define TUPM_OFF_CAPT 13'h1D88
`define TUPM_OFF_SCR 13'h1DF8
`define TUPM_OFF_CFG 13'h1E00
`define TUPM_OFF_CTRL 13'h1E04
`define TUPM_OFF_SNAP 13'h0600

// Capability register fields
`define TUPM_CFG_COUNTER_NUMBER_FIELD_LSB 0
`define TUPM_CFG_SIZE_LSB 8
`define TUPM_CFG_MPAM_BIT 18
`define TUPM_CFG_RELOC_BIT 20
`define TUPM_CFG_MSI_BIT 21
`define TUPM_CFG_CAPT_BIT 22
`define TUPM_CFG_FILT_BIT 23
`define TUPM_CFG_SIZE_VAL 6'h31
`define TUPM_CFG_MPAM_VAL 1'h0
`define TUPM_CFG_RELOC_VAL 1'h1
`define TUPM_CFG_MSI_VAL 1'h0
`define TUPM_CFG_CAPT_VAL 1'h1
`define TUPM_CFG_FILT_VAL 1'h1

// Filter, control, security and capture fields and reset values
`define TUPM_FILT_ALL_BIT 31
`define TUPM_FILT_RST 32'h80000000
`define TUPM_CTRL_EN_BIT 0
`define TUPM_SCR_SO_BIT 0
`define TUPM_CAPT_BIT 0

`endif

// ===== common/tupm_pkg.sv
// Types of the translation unit performance monitor counter group
package tupm_pkg;
`include "tupm_defs.svh"

   typedef struct packed {
      logic wbuf_full;
      logic mkinv_down;
      logic rdonce_mkinv_down;
      logic lti_dcmo_down;
      logic wrstash_down;
      logic stashonce_term;
      logic stashonce_term_dis;
      logic lti_wdcp_down;
      logic lti_dcp_razwi;
      logic lti_abort_dis;
      logic [`TUPM_SID_W-1:0] sid;
   } tupm_evt_s;

   typedef struct packed {
      logic read;
      logic write;
      logic [`TUPM_ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } tupm_avs_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } tupm_avs_rsp_s;

   typedef enum logic {TUPM_SNAP_IDLE, TUPM_SNAP_ACK} tupm_snap_e;

   typedef struct packed {
      logic [`TUPM_COUNTER_NUMBER_FIELD-1:0][`TUPM_CTR_W-1:0] cnt;
      logic [`TUPM_COUNTER_NUMBER_FIELD-1:0][`TUPM_CTR_W-1:0] snap;
      logic [`TUPM_COUNTER_NUMBER_FIELD-1:0][7:0] evt_code;
      logic [`TUPM_COUNTER_NUMBER_FIELD-1:0] cnt_en;
      logic [31:0] filt;
      logic glob_en;
      logic sec_obs;
      logic req_sync1;
      logic req_sync2;
      logic req_prev;
      tupm_snap_e snap_st;
      logic ack;
      logic waitreq;
      logic [31:0] rdata;
   } tupm_state_s;

endpackage

// ===== hw/tupm_counter_group.sv
// Performance monitor counter group of a translation buffer unit
`timescale 1ns/1ps
`include "tupm_defs.svh"

module tupm_counter_group
   import tupm_pkg::*;
#(
   parameter bit LTI_VARIANT = 1'b0
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Register bus
   input wire tupm_avs_req_s avs_req,
   output tupm_avs_rsp_s avs_rsp,
   // Events from the translation datapath
   input wire tupm_evt_s evt,
   // Snapshot handshake
   input wire logic snap_req,
   output logic snap_ack
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tupm_state_s state_reg;
   tupm_state_s state_next;

   logic [1:0] amt_wbuf;
   logic [1:0] amt_dcmo;
   logic [1:0] amt_stash;
   logic sid_match;
   logic [`TUPM_COUNTER_NUMBER_FIELD-1:0][1:0] inc;
   logic [31:0] cfg_val;

   // ----------------------------------------------------------------
   // Event qualification
   // ----------------------------------------------------------------
   // Stream filter for the DCMO and stash events; write buffer events are not filtered
   assign sid_match = state_reg.filt[`TUPM_FILT_ALL_BIT]
      | (state_reg.filt[`TUPM_SID_W-1:0] == evt.sid);

   assign amt_wbuf = {1'b0, evt.wbuf_full & state_reg.sec_obs};

   always_comb begin
      amt_dcmo = 2'h0;
      amt_stash = 2'h0;
      if (LTI_VARIANT) begin
         amt_dcmo = {1'b0, evt.lti_dcmo_down};
         amt_stash = {1'b0, evt.lti_wdcp_down}
            + {1'b0, evt.lti_dcp_razwi & ~evt.lti_abort_dis};
      end else begin
         amt_dcmo = {1'b0, evt.mkinv_down} + {1'b0, evt.rdonce_mkinv_down};
         amt_stash = {1'b0, evt.wrstash_down}
            + {1'b0, evt.stashonce_term & ~evt.stashonce_term_dis};
      end
      if (!sid_match) begin
         amt_dcmo = 2'h0;
         amt_stash = 2'h0;
      end
   end

   // ----------------------------------------------------------------
   // Per-counter increment select
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `TUPM_COUNTER_NUMBER_FIELD; gi = gi + 1) begin : g_inc
         always_comb begin
            inc[gi] = 2'h0;
            if (state_reg.glob_en && state_reg.cnt_en[gi]) begin
               case (state_reg.evt_code[gi])
                  `TUPM_EVT_WBUF_FULL: inc[gi] = amt_wbuf;
                  `TUPM_EVT_DCMO_DOWN: inc[gi] = amt_dcmo;
                  `TUPM_EVT_STASH_FAIL: inc[gi] = amt_stash;
                  default: inc[gi] = 2'h0;
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Capability word
   // ----------------------------------------------------------------
   always_comb begin
      cfg_val = 32'h00000000;
      cfg_val[`TUPM_CFG_COUNTER_NUMBER_FIELD_LSB +: 6] = 6'(`TUPM_COUNTER_NUMBER_FIELD - 1);
      cfg_val[`TUPM_CFG_SIZE_LSB +: 6] = `TUPM_CFG_SIZE_VAL;
      cfg_val[`TUPM_CFG_MPAM_BIT] = `TUPM_CFG_MPAM_VAL;
      cfg_val[`TUPM_CFG_RELOC_BIT] = `TUPM_CFG_RELOC_VAL;
      cfg_val[`TUPM_CFG_MSI_BIT] = `TUPM_CFG_MSI_VAL;
      cfg_val[`TUPM_CFG_CAPT_BIT] = `TUPM_CFG_CAPT_VAL;
      cfg_val[`TUPM_CFG_FILT_BIT] = `TUPM_CFG_FILT_VAL;
   end

   // ----------------------------------------------------------------
   // Byte-enable merge
   // ----------------------------------------------------------------
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] be
   );
      logic [31:0] res;
      integer b;
      res = old_v;
      for (b = 0; b < 4; b = b + 1) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Region hit for an arrayed register block
   function automatic logic in_region(
      input logic [`TUPM_ADDR_W-1:0] addr,
      input logic [`TUPM_ADDR_W-1:0] base
   );
      return (addr[`TUPM_ADDR_W-1:8] == base[`TUPM_ADDR_W-1:8])
         && (addr[1:0] == 2'h0)
         && (addr[7:2] < `TUPM_IDX_W'(`TUPM_COUNTER_NUMBER_FIELD));
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [`TUPM_IDX_W-1:0] idx;
      logic wr_go;
      logic rd_go;
      logic capture;
      logic req_rise;
      logic [31:0] rd_val;
      integer i;
      idx = avs_req.address[7:2];
      wr_go = 1'b0;
      rd_go = 1'b0;
      capture = 1'b0;
      req_rise = 1'b0;
      rd_val = 32'h00000000;
      state_next = state_reg;

      // Write accepted at the edge where waitrequest is low, read at the edge where it is high
      wr_go = avs_req.write & ~state_reg.waitreq;
      rd_go = avs_req.read & state_reg.waitreq;
      state_next.waitreq = ~((avs_req.read | avs_req.write)
         & state_reg.waitreq);

      // ----------------------------------------------------------------
      // Snapshot request synchroniser
      // ----------------------------------------------------------------
      // Two-stage synchroniser
      state_next.req_sync1 = snap_req;
      state_next.req_sync2 = state_reg.req_sync1;
      state_next.req_prev = state_reg.req_sync2;
      req_rise = state_reg.req_sync2 & ~state_reg.req_prev;

      // ----------------------------------------------------------------
      // Snapshot handshake
      // ----------------------------------------------------------------
      case (state_reg.snap_st)
         TUPM_SNAP_IDLE: begin
            if (req_rise) begin
               capture = 1'b1;
               state_next.ack = 1'b1;
               state_next.snap_st = TUPM_SNAP_ACK;
            end
         end
         TUPM_SNAP_ACK: begin
            if (!state_reg.req_sync2) begin
               state_next.ack = 1'b0;
               state_next.snap_st = TUPM_SNAP_IDLE;
            end
         end
         default: begin
            state_next.ack = 1'b0;
            state_next.snap_st = TUPM_SNAP_IDLE;
         end
      endcase

      if (wr_go && avs_req.address == `TUPM_OFF_CAPT
            && avs_req.byteenable[0]
            && avs_req.writedata[`TUPM_CAPT_BIT]) begin
         capture = 1'b1;
      end

      // ----------------------------------------------------------------
      // Counters and snapshots
      // ----------------------------------------------------------------
      for (i = 0; i < `TUPM_COUNTER_NUMBER_FIELD; i = i + 1) begin
         if (capture) begin
            state_next.snap[i] = state_reg.cnt[i];
         end
         state_next.cnt[i] = state_reg.cnt[i]
            + `TUPM_CTR_W'(inc[i]);
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (wr_go) begin
         if (in_region(avs_req.address, `TUPM_OFF_CNT)) begin
            state_next.cnt[idx] = be_merge(state_reg.cnt[idx],
               avs_req.writedata, avs_req.byteenable);
         end
         if (in_region(avs_req.address, `TUPM_OFF_EVT)
               && avs_req.byteenable[0]) begin
            state_next.evt_code[idx] = avs_req.writedata[7:0];
         end
         if (avs_req.address == `TUPM_OFF_FILT) begin
            state_next.filt = be_merge(state_reg.filt,
               avs_req.writedata, avs_req.byteenable);
         end
         if (avs_req.address == `TUPM_OFF_CNTEN
               && avs_req.byteenable[0]) begin
            state_next.cnt_en = avs_req.writedata[`TUPM_COUNTER_NUMBER_FIELD-1:0];
         end
         if (avs_req.address == `TUPM_OFF_CTRL
               && avs_req.byteenable[0]) begin
            state_next.glob_en = avs_req.writedata[`TUPM_CTRL_EN_BIT];
         end
         if (avs_req.address == `TUPM_OFF_SCR
               && avs_req.byteenable[0]) begin
            state_next.sec_obs = avs_req.writedata[`TUPM_SCR_SO_BIT];
         end
      end

      // ----------------------------------------------------------------
      // Register reads
      // ----------------------------------------------------------------
      if (in_region(avs_req.address, `TUPM_OFF_CNT)) begin
         rd_val = state_reg.cnt[idx];
      end else if (in_region(avs_req.address, `TUPM_OFF_SNAP)) begin
         rd_val = state_reg.snap[idx];
      end else if (in_region(avs_req.address, `TUPM_OFF_EVT)) begin
         rd_val = {24'h000000, state_reg.evt_code[idx]};
      end else begin
         case (avs_req.address)
            `TUPM_OFF_FILT: rd_val = state_reg.filt;
            `TUPM_OFF_CNTEN: rd_val = 32'(state_reg.cnt_en);
            `TUPM_OFF_CTRL: rd_val = 32'(state_reg.glob_en);
            `TUPM_OFF_SCR: rd_val = 32'(state_reg.sec_obs);
            `TUPM_OFF_CFG: rd_val = cfg_val;
            default: rd_val = 32'h00000000;
         endcase
      end
      if (rd_go) begin
         state_next.rdata = rd_val;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_reg <= '0;
         state_reg.filt <= `TUPM_FILT_RST;
         state_reg.waitreq <= 1'b1;
         state_reg.snap_st <= TUPM_SNAP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_rsp.readdata = state_reg.rdata;
   assign avs_rsp.waitrequest = state_reg.waitreq;
   assign snap_ack = state_reg.ack;

endmodule // tupm_counter_group

// ===== test/tupm_counter_group_properties.sv
// Concurrent checks on the counter group ports
`timescale 1ns/1ps
`include "tupm_defs.svh"

module tupm_counter_group_checker
   import tupm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Register bus
   input wire tupm_avs_req_s avs_req,
   input wire tupm_avs_rsp_s avs_rsp,
   // Events and snapshot link
   input wire tupm_evt_s evt,
   input wire logic snap_req,
   input wire logic snap_ack
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------
   // Snapshot link
   // ----------------------------------------
   a_ack_reset_low: assert property ($rose(resetn) |-> !snap_ack && avs_rsp.waitrequest)
      else $error("ack or waitrequest wrong after reset");
   a_ack_rise_sync: assert property ($rose(snap_ack) |-> $past(snap_req, 1) && $past(snap_req, 2))
      else $error("ack rose before request passed the synchroniser");
   a_ack_rise_bound: assert property ($rose(snap_req) && !snap_ack |-> ##[1:4] snap_ack)
      else $error("ack did not follow request rise");
   a_ack_fall_sync: assert property ($fell(snap_ack) |-> !$past(snap_req, 2))
      else $error("ack fell while request high");
   a_ack_fall_bound: assert property ($fell(snap_req) && snap_ack |-> ##[1:4] !snap_ack)
      else $error("ack did not follow request fall");
   a_ack_hold_high: assert property (snap_ack && snap_req |=> snap_ack)
      else $error("ack dropped while request high");
   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   a_wait_one_state: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
      else $error("waitrequest not low after one wait state");
   a_wait_single_low: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_idle_high: assert property (!avs_req.read && !avs_req.write && avs_rsp.waitrequest |=> avs_rsp.waitrequest)
      else $error("waitrequest low without request");
   a_caps_value: assert property (avs_req.read && avs_req.address == `TUPM_OFF_CFG && avs_rsp.waitrequest
      |=> avs_rsp.readdata == 32'h00D03103)
      else $error("capabilities read wrong");
   c_snap_ack: cover property ($rose(snap_ack));
   c_snap_done: cover property ($fell(snap_ack));
   c_bus_write: cover property (avs_req.write && !avs_rsp.waitrequest);
endmodule // tupm_counter_group_checker

bind tupm_counter_group tupm_counter_group_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
   .avs_req(avs_req), .avs_rsp(avs_rsp), .evt(evt), .snap_req(snap_req), .snap_ack(snap_ack));

// ===== test/tupm_snap_requester.sv
// Snapshot requester model on the far side of the snapshot link
`timescale 1ns/1ps

module tupm_snap_requester (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Control from the bench
   input wire logic go,
   input wire logic [3:0] linger,
   output logic [7:0] done_cnt = 8'h0,
   // Snapshot link
   input wire logic snap_ack,
   output logic snap_req = 1'b0
);

   always begin
      @(posedge sys_clk);
      if (go === 1'b1 && resetn === 1'b1) begin
         while (snap_ack !== 1'b0) @(posedge sys_clk);
         snap_req <= 1'b1;
         do @(posedge sys_clk); while (snap_ack !== 1'b1);
         repeat (linger) @(posedge sys_clk);
         snap_req <= 1'b0;
         do @(posedge sys_clk); while (snap_ack !== 1'b0);
         done_cnt <= done_cnt + 8'h1;
      end
   end
endmodule // tupm_snap_requester

// ===== test/tb_tupm_counter_group.sv
// Self-checking bench of the counter group
`timescale 1ns/1ps
`include "tupm_defs.svh"

module tb_tupm_counter_group
   import tupm_pkg::*;
;
   localparam logic [31:0] CFG_EXP = (32'h1 << 23) | (32'h1 << 22) | (32'h1 << 20) | (32'h31 << 8) | (`TUPM_COUNTER_NUMBER_FIELD - 1);
   logic sys_clk = 1'b0;
   logic resetn;
   tupm_avs_req_s avs_req;
   tupm_avs_rsp_s avs_rsp;
   tupm_avs_rsp_s avs_rsp_l;
   logic snap_ack_l;
   logic [31:0] rd_l;
   tupm_evt_s evt;
   logic snap_req;
   logic snap_ack;
   logic go;
   logic [3:0] linger;
   logic [7:0] done_cnt;
   logic [31:0] rd;
   logic [31:0] exp_cnt [4] = '{32'h5, 32'h6, 32'h5, 32'h6};
   int failures = 0;
   int n_checks = 0;

   always #4 sys_clk = ~sys_clk;

   tupm_counter_group #(.LTI_VARIANT(1'b0)) uut (.sys_clk(sys_clk), .resetn(resetn), .avs_req(avs_req),
      .avs_rsp(avs_rsp), .evt(evt), .snap_req(snap_req), .snap_ack(snap_ack));
   // LTI variant sees the same bus and events
   tupm_counter_group #(.LTI_VARIANT(1'b1)) uut_lti (.sys_clk(sys_clk), .resetn(resetn), .avs_req(avs_req),
      .avs_rsp(avs_rsp_l), .evt(evt), .snap_req(snap_req), .snap_ack(snap_ack_l));
   tupm_snap_requester req_model (.sys_clk(sys_clk), .resetn(resetn), .go(go), .linger(linger),
      .done_cnt(done_cnt), .snap_ack(snap_ack), .snap_req(snap_req));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic err(input string msg);
      failures++;
      $display("ERROR %0t %s", $time, msg);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) err($sformatf("got %h expected %h", got, exp));
   endtask

   task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
      @(posedge sys_clk);
      while (avs_rsp.waitrequest !== 1'b0 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 50) err("bus timeout");
      rd = avs_rsp.readdata;
      rd_l = avs_rsp_l.readdata;
      avs_req <= '0;
      @(posedge sys_clk);
   endtask

   task automatic rchk(input logic [12:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic pulse(input logic [9:0] f, input logic [15:0] sid, input int n);
      evt <= tupm_evt_s'({f, sid});
      repeat (n) @(posedge sys_clk);
      evt <= '0;
      @(posedge sys_clk);
   endtask

   task automatic snapshot(input logic [3:0] l);
      logic [7:0] c0;
      int n;
      c0 = done_cnt;
      n = 0;
      linger <= l;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      while (done_cnt === c0 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 100) err("snapshot timeout");
   endtask

   task automatic results();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #(8 * 5000);
      err("watchdog expired");
      results();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      resetn = 1'b0;
      avs_req = '0;
      evt = '0;
      go = 1'b0;
      linger = 4'h0;
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rchk(`TUPM_OFF_FILT, `TUPM_FILT_RST);
      rchk(`TUPM_OFF_SCR, 32'h0);
      rchk(`TUPM_OFF_CFG, CFG_EXP);
      bus(1'b1, `TUPM_OFF_CFG, 32'h0);
      rchk(`TUPM_OFF_CFG, CFG_EXP);
      rchk(13'h0100, 32'h0);
      $display("test caps finished");
      bus(1'b1, `TUPM_OFF_EVT, {24'h0, `TUPM_EVT_WBUF_FULL});
      bus(1'b1, `TUPM_OFF_EVT + 13'h4, {24'h0, `TUPM_EVT_DCMO_DOWN});
      bus(1'b1, `TUPM_OFF_EVT + 13'h8, {24'h0, `TUPM_EVT_STASH_FAIL});
      bus(1'b1, `TUPM_OFF_EVT + 13'hC, {24'h0, `TUPM_EVT_DCMO_DOWN});
      bus(1'b1, `TUPM_OFF_FILT, 32'h5);
      bus(1'b1, `TUPM_OFF_CNTEN, 32'hF);
      bus(1'b1, `TUPM_OFF_CTRL, 32'h1);
      pulse(10'h200, 16'h9, 5);
      rchk(`TUPM_OFF_CNT, 32'h0);
      bus(1'b1, `TUPM_OFF_SCR, 32'h1);
      pulse(10'h200, 16'h9, 5);
      rchk(`TUPM_OFF_CNT, 32'h5);
      pulse(10'h180, 16'h5, 3);
      pulse(10'h180, 16'h6, 3);
      pulse(10'h040, 16'h5, 2);
      pulse(10'h040, 16'h6, 1);
      rchk(`TUPM_OFF_CNT + 13'h4, 32'h6);
      chk(rd_l, 32'h2);
      rchk(`TUPM_OFF_CNT + 13'hC, 32'h6);
      chk(rd_l, 32'h2);
      pulse(10'h020, 16'h5, 2);
      pulse(10'h010, 16'h5, 3);
      pulse(10'h018, 16'h5, 4);
      pulse(10'h004, 16'h5, 2);
      pulse(10'h002, 16'h5, 3);
      pulse(10'h003, 16'h5, 4);
      rchk(`TUPM_OFF_CNT + 13'h8, 32'h5);
      chk(rd_l, 32'h5);
      $display("test events finished");
      snapshot(4'h0);
      for (int i = 0; i < 4; i++) rchk(`TUPM_OFF_SNAP + 13'(4 * i), exp_cnt[i]);
      chk({31'h0, snap_ack}, 32'h0);
      pulse(10'h200, 16'h9, 2);
      rchk(`TUPM_OFF_SNAP, 32'h5);
      bus(1'b1, `TUPM_OFF_CAPT, 32'h1);
      rchk(`TUPM_OFF_SNAP, 32'h7);
      pulse(10'h200, 16'h9, 1);
      snapshot(4'h6);
      rchk(`TUPM_OFF_SNAP, 32'h8);
      rchk(`TUPM_OFF_SNAP + 13'h4, 32'h6);
      chk(rd_l, 32'h2);
      chk({31'h0, snap_ack}, 32'h0);
      chk({31'h0, snap_ack_l}, 32'h0);
      $display("test snapshot finished");
      results();
   end
endmodule // tb_tupm_counter_group
